// >>> src/pmic_defs.svh
// constants of the power-unit control and status logic
// What this block does
// R1 - charger enable bit, resets to on
// R2 - first buck enable bit, resets to on
// R3 - second buck enable bit, resets to on
// R4 - linregs one, three, four, five enables
// R5 - linreg two needs enable and pin
// R6 - power pin mask blocks pin over buck two
// R7 - deep sleep ready flag, resets to zero
// R8 - force deep sleep bit, resets to zero
// R9 - five event masks suppress interrupt, reset one
// R10 - status read returns one fixed-layout byte
// R11 - host reads at full address byte 9D
// R12 - open-drain interrupt pulls low on events
// R13 - interrupt released after completed read
// R14 - supply crossing lockout sets arrived or removed
// R15 - charger watchdog timeout sets its flag
// R16 - low battery comparator sets its flag
// R17 - end of charge sets its flag
// R18 - third byte only after group zero
// R19 - interrupt is OR of unmasked flags
// R20 - returned flags clear after completed read
`ifndef PMIC_DEFS_SVH
`define PMIC_DEFS_SVH

// ***************************
// bus address and groups
// ***************************
`define DEV_ADDR 7'h4E
`define GRP_SELECT 3'h0
`define GRP_MISC 3'h1
`define GRP_VOLT 3'h2
`define SUB_ENABLES 2'h1
`define SUB_MASKS 2'h2
`define GSEL_MAIN 3'h0

// ***************************
// status byte bit positions
// ***************************
`define ST_ARRIVED 7
`define ST_REMOVED 6
`define ST_LOWBAT 4
`define ST_TIMEOUT 3
`define ST_DONE 2
`define ST_DSR 1
`define ST_FDS 0

// ***************************
// reset values
// ***************************
`define RST_RAIL_ON 1'h1
`define RST_PIN_MASK 1'h1
`define RST_EVT_MASK 5'h1F
`define RST_DSR 1'h0
`define RST_FDS 1'h0
`define RST_PINS 7'h03

`endif

// >>> src/pmic_pkg.sv
// types of the power-unit control and status logic
package pmic_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011
  } link_state_t;

endpackage : pmic_pkg

// >>> src/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // pins in, filtered levels out
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_lvl
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
      o_lvl <= RST;
    end
    else if (i_ce)
    begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // change counts once stages two and three agree
      o_lvl <= (s2_ff & s3_ff) | (o_lvl & (s2_ff | s3_ff));
    end
  end

endmodule : pin_sync

// >>> src/event_latch.sv
// sticky event flag, set wins over clear
`timescale 1ns/1ps
module event_latch (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // set and clear
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_flag
);

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_flag <= 1'b0;
    else if (i_ce)
      o_flag <= i_set | (o_flag & ~i_clr);
  end

endmodule : event_latch

// >>> src/pmic_ctrl.sv
// power-unit control registers, event flags and two-wire slave
`timescale 1ns/1ps
`include "pmic_defs.svh"
module pmic_ctrl
  import pmic_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // open-drain interrupt pin
  output logic o_int_o,
  output logic o_int_oe,
  // analog monitors and enable pin
  input wire logic i_above_undervoltage_lockout,
  input wire logic i_charge_timeout,
  input wire logic i_low_battery,
  input wire logic i_charge_done,
  input wire logic i_power_enable_pin,
  // rail controls
  output logic o_charger_on,
  output logic o_buck_one_on,
  output logic o_buck_two_on,
  output logic o_linreg_one_on,
  output logic o_linreg_two_on,
  output logic o_linreg_three_on,
  output logic o_linreg_four_on,
  output logic o_linreg_five_on,
  // sleep controls
  output logic o_deep_sleep_ready,
  output logic o_force_deep_sleep
);

  // ***************************
  // pin synchronisers
  // ***************************
  logic [6:0] raw_pins, syn_pins;
  logic scl_s, sda_s, undervoltage_lockout_s, timeout_s, lowbat_s, done_s, power_enable_pin;

  assign raw_pins = {i_power_enable_pin, i_charge_done, i_low_battery,
                     i_charge_timeout, i_above_undervoltage_lockout, i_sda, i_scl};

  pin_sync #(
    .W(7),
    .RST(`RST_PINS)
  ) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_pin(raw_pins),
    .o_lvl(syn_pins)
  );

  assign scl_s = syn_pins[0];
  assign sda_s = syn_pins[1];
  assign undervoltage_lockout_s = syn_pins[2];
  assign timeout_s = syn_pins[3];
  assign lowbat_s = syn_pins[4];
  assign done_s = syn_pins[5];
  assign power_enable_pin = syn_pins[6];

  // ***************************
  // edge detection
  // ***************************
  logic scl_q_ff, sda_q_ff, scl_rise, scl_fall, bus_start, bus_stop;
  logic [3:0] mon_q_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      mon_q_ff <= 4'h0;
    end
    else if (i_ce)
    begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      mon_q_ff <= {done_s, lowbat_s, timeout_s, undervoltage_lockout_s};
    end
  end

  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;
  assign bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign bus_stop = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  // ***************************
  // control registers
  // ***************************
  logic charger_on_ff, en_b1_ff, en_b2_ff, en_l1_ff, en_l2_ff, en_l3_ff, en_l4_ff, en_l5_ff;
  logic pin_mask_ff, dsr_ff, fds_ff, third_ok_ff;
  logic [4:0] mask_ff;
  logic [2:0] gsel_ff;

  // ***************************
  // link state
  // ***************************
  link_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff, rd_shift_ff, status;
  logic [4:0] snap_ff, evt;
  logic rw_ff, idx_ff, wr_stb, rd_done, ld_rd;

  // status byte layout
  assign status = {evt[4], evt[3], 1'b0, evt[2], evt[1], evt[0], dsr_ff, fds_ff}; // R10

  assign wr_stb = i_ce & scl_fall & (state_ff == ST_WDATA) & (cnt_ff == 4'h7);
  assign ld_rd = i_ce & scl_fall & (state_ff == ST_ADDR) & (cnt_ff == 4'h8) & rw_ff;
  assign rd_done = i_ce & scl_rise & (state_ff == ST_RDATA) & (cnt_ff == 4'h8); // R13

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rd_shift_ff <= 8'h00;
      snap_ff <= 5'h00;
      rw_ff <= 1'b0;
      idx_ff <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      if (bus_start)
      begin
        state_ff <= ST_ADDR;
        // first fall after start comes before the first bit
        cnt_ff <= 4'hF;
        o_sda_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_ff <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (cnt_ff < 4'h8)
          shift_ff <= {shift_ff[6:0], sda_s};
      end
      else if (scl_fall)
      begin
        unique case (state_ff)
          ST_IDLE: o_sda_oe <= 1'b0;
          ST_ADDR:
          begin
            if (cnt_ff == 4'h7)
            begin
              // answer only our own address
              if (shift_ff[7:1] == `DEV_ADDR) // R11
              begin
                o_sda_oe <= 1'b1;
                rw_ff <= shift_ff[0];
                cnt_ff <= 4'h8;
              end
              else
                state_ff <= ST_IDLE;
            end
            else if (cnt_ff == 4'h8)
            begin
              cnt_ff <= 4'h0;
              idx_ff <= 1'b0;
              if (rw_ff)
              begin
                state_ff <= ST_RDATA;
                rd_shift_ff <= {status[6:0], 1'b0};
                snap_ff <= evt;
                o_sda_oe <= ~status[7]; // R10
              end
              else
              begin
                state_ff <= ST_WDATA;
                o_sda_oe <= 1'b0;
              end
            end
            else
              cnt_ff <= cnt_ff + 4'h1;
          end
          ST_WDATA:
          begin
            if (cnt_ff == 4'h7)
            begin
              o_sda_oe <= 1'b1;
              cnt_ff <= 4'h8;
            end
            else if (cnt_ff == 4'h8)
            begin
              o_sda_oe <= 1'b0;
              cnt_ff <= 4'h0;
              idx_ff <= 1'b1;
            end
            else
              cnt_ff <= cnt_ff + 4'h1;
          end
          ST_RDATA:
          begin
            // one byte only, then let go of the line
            if (cnt_ff < 4'h7)
            begin
              o_sda_oe <= ~rd_shift_ff[7];
              rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
            else if (cnt_ff == 4'h7)
            begin
              o_sda_oe <= 1'b0;
              cnt_ff <= 4'h8;
            end
            else
            begin
              o_sda_oe <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign o_sda_o = 1'b0;

  // ***************************
  // register writes
  // ***************************
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      charger_on_ff <= `RST_RAIL_ON; // R1
      en_b1_ff <= `RST_RAIL_ON; // R2
      en_b2_ff <= `RST_RAIL_ON; // R3
      en_l1_ff <= `RST_RAIL_ON; // R4
      en_l2_ff <= `RST_RAIL_ON; // R5
      en_l3_ff <= `RST_RAIL_ON; // R4
      en_l4_ff <= `RST_RAIL_ON; // R4
      en_l5_ff <= `RST_RAIL_ON; // R4
      pin_mask_ff <= `RST_PIN_MASK; // R6
      dsr_ff <= `RST_DSR; // R7
      fds_ff <= `RST_FDS; // R8
      mask_ff <= `RST_EVT_MASK; // R9
      gsel_ff <= `GSEL_MAIN;
      third_ok_ff <= 1'b0;
    end
    else if (wr_stb)
    begin
      if (!idx_ff)
      begin
        third_ok_ff <= (shift_ff[7:5] == `GRP_SELECT); // R18
        case (shift_ff[7:5])
          `GRP_SELECT: gsel_ff <= shift_ff[2:0];
          `GRP_MISC:
          begin
            en_l5_ff <= shift_ff[4]; // R4
            en_l4_ff <= shift_ff[3]; // R4
            dsr_ff <= shift_ff[2]; // R7
            fds_ff <= shift_ff[1]; // R8
          end
          `GRP_VOLT: charger_on_ff <= shift_ff[0]; // R1
          default: third_ok_ff <= 1'b0;
        endcase
      end
      else if (third_ok_ff && gsel_ff == `GSEL_MAIN) // R18
      begin
        third_ok_ff <= 1'b0;
        if (shift_ff[7:6] == `SUB_ENABLES)
        begin
          en_l3_ff <= shift_ff[5]; // R4
          en_l2_ff <= shift_ff[4]; // R5
          en_l1_ff <= shift_ff[3]; // R4
          en_b1_ff <= shift_ff[2]; // R2
          en_b2_ff <= shift_ff[1]; // R3
          pin_mask_ff <= shift_ff[0]; // R6
        end
        else if (shift_ff[7:6] == `SUB_MASKS)
          mask_ff <= {shift_ff[5:4], shift_ff[2:0]}; // R9
      end
    end
  end

  // ***************************
  // event flags
  // ***************************
  logic [4:0] evt_set;

  assign evt_set[4] = i_ce & undervoltage_lockout_s & ~mon_q_ff[0]; // R14
  assign evt_set[3] = i_ce & ~undervoltage_lockout_s & mon_q_ff[0]; // R14
  assign evt_set[2] = i_ce & lowbat_s & ~mon_q_ff[2]; // R16
  assign evt_set[1] = i_ce & timeout_s & ~mon_q_ff[1]; // R15
  assign evt_set[0] = i_ce & done_s & ~mon_q_ff[3]; // R17

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_evt
      event_latch u_flag (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_set(evt_set[gi]),
        .i_clr(rd_done & snap_ff[gi]), // R20
        .o_flag(evt[gi])
      );
    end
  endgenerate

  // ***************************
  // outputs
  // ***************************
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_int_oe <= 1'b0;
      o_charger_on <= 1'b0;
      o_buck_one_on <= 1'b0;
      o_buck_two_on <= 1'b0;
      o_linreg_one_on <= 1'b0;
      o_linreg_two_on <= 1'b0;
      o_linreg_three_on <= 1'b0;
      o_linreg_four_on <= 1'b0;
      o_linreg_five_on <= 1'b0;
      o_deep_sleep_ready <= 1'b0;
      o_force_deep_sleep <= 1'b0;
    end
    else if (i_ce)
    begin
      // sleep bits never reach the interrupt
      o_int_oe <= |(evt & ~mask_ff); // R12 R19
      o_charger_on <= charger_on_ff; // R1
      o_buck_one_on <= en_b1_ff; // R2
      o_buck_two_on <= en_b2_ff & (pin_mask_ff | power_enable_pin); // R3 R6
      o_linreg_one_on <= en_l1_ff; // R4
      o_linreg_two_on <= en_l2_ff & power_enable_pin; // R5
      o_linreg_three_on <= en_l3_ff; // R4
      o_linreg_four_on <= en_l4_ff; // R4
      o_linreg_five_on <= en_l5_ff; // R4
      o_deep_sleep_ready <= dsr_ff; // R7
      o_force_deep_sleep <= fds_ff; // R8
    end
  end

  assign o_int_o = 1'b0;

  // ***************************
  // assertions
  // ***************************
  AST_RESET_DEFAULTS: assert property (@(posedge i_clk) // R1 R2 R3 R4 R7 R8 R9
    !i_nrst |=> (charger_on_ff && en_b1_ff && en_b2_ff && en_l1_ff && en_l3_ff
      && en_l4_ff && en_l5_ff && pin_mask_ff && !dsr_ff && !fds_ff
      && mask_ff == 5'h1F))
    else $error("control defaults wrong after reset");

  AST_LINREG_TWO_PIN: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
    o_linreg_two_on |-> $past(en_l2_ff) && $past(power_enable_pin))
    else $error("linreg two on without enable and pin");

  AST_PIN_MASKED: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
    ($past(i_nrst) && $past(i_ce) && $past(pin_mask_ff)) |-> o_buck_two_on == $past(en_b2_ff))
    else $error("masked pin affected buck two");

  AST_FORCE_SLEEP: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
    (wr_stb && !idx_ff && shift_ff[7:5] == 3'h1 && shift_ff[1]) |=> ##1 o_force_deep_sleep)
    else $error("force deep sleep write not applied");

  AST_READ_BYTE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
    ld_rd |=> (rd_shift_ff == {$past(status[6:0]), 1'b0}) && o_sda_oe == !$past(status[7]))
    else $error("status byte not loaded");

  AST_INT_UNMASKED: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12 R16 R19
    (i_ce && evt[2] && !mask_ff[2]) |=> o_int_oe)
    else $error("unmasked low battery did not pull interrupt");

  AST_INT_RELEASE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R13
    $fell(o_int_oe) |-> $past(rd_done || wr_stb, 2) || $past(rd_done || wr_stb))
    else $error("interrupt released without read or mask write");

  AST_UNDERVOLTAGE_LOCKOUT_RISE: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
    evt_set[4] |=> evt[4] && !evt_set[3])
    else $error("supply arrival not latched");

  AST_TIMEOUT_SET: assert property (@(posedge i_clk) disable iff (!i_nrst) // R15
    evt_set[1] |=> evt[1])
    else $error("timeout event lost");

  AST_DONE_CLEAR: assert property (@(posedge i_clk) disable iff (!i_nrst) // R17 R20
    (rd_done && snap_ff[0] && !evt_set[0]) |=> !evt[0])
    else $error("returned charge done flag not cleared");

  AST_THIRD_GUARD: assert property (@(posedge i_clk) disable iff (!i_nrst) // R18
    (wr_stb && idx_ff && !(third_ok_ff && gsel_ff == `GSEL_MAIN))
      |=> $stable(mask_ff) && $stable(en_l1_ff))
    else $error("third byte applied without group select");

endmodule : pmic_ctrl

// >>> dv/host_model.sv
// two-wire bus host model driving the device pins
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic i_clk,
  // device data pull-down
  input wire logic i_sda_oe,
  // bus pins
  output logic o_scl,
  output logic o_sda_low
);
  logic sda_line;
  // pulled-up data line
  assign sda_line = ~(o_sda_low | i_sda_oe);
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // one bit slot, data changes mid low phase
  task automatic bus_bit(input logic b, output logic r);
    // 80 ns slot: six clocks low, two high
    o_scl <= 1'b0;
    tick(3);
    o_sda_low <= ~b;
    tick(3);
    o_scl <= 1'b1;
    tick(1);
    r = sda_line;
    tick(1);
  endtask : bus_bit
  task automatic bus_byte(input logic [7:0] w, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bus_bit(w[i], r[i]);
    bus_bit(1'b1, a);
    ack = ~a;
  endtask : bus_byte
  task automatic bus_start;
    o_sda_low <= 1'b1;
    tick(6);
  endtask : bus_start
  task automatic bus_stop;
    o_scl <= 1'b0;
    tick(4);
    o_sda_low <= 1'b1;
    tick(3);
    o_scl <= 1'b1;
    tick(6);
    o_sda_low <= 1'b0;
    tick(6);
  endtask : bus_stop
  task automatic write_cmd(input logic [7:0] b2, input logic [7:0] b3, input bit three,
                           output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    bus_start();
    bus_byte(8'h9C, r, a0);
    bus_byte(b2, r, a1);
    a2 = 1'b1;
    if (three && b2[7:5] == 3'h0) bus_byte(b3, r, a2);
    bus_stop();
    ok = a0 & a1 & a2;
  endtask : write_cmd
  task automatic read_status(output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a;
    bus_start();
    bus_byte(8'h9D, r, ok);
    bus_byte(8'hFF, d, a);
    bus_stop();
  endtask : read_status
endmodule : host_model

// >>> dv/tb_top.sv
// self-checking bench of the power-unit control block
`timescale 1ns/1ps
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb_top
  import pmic_pkg::*;
;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_scl, i_sda, sda_low;
  logic i_above_undervoltage_lockout = 1'b0, i_charge_timeout = 1'b0, i_low_battery = 1'b0;
  logic i_charge_done = 1'b0, i_power_enable_pin = 1'b1;
  logic o_sda_o, o_sda_oe, o_int_o, o_int_oe, o_charger_on, o_buck_one_on, o_buck_two_on;
  logic o_linreg_one_on, o_linreg_two_on, o_linreg_three_on, o_linreg_four_on;
  logic o_linreg_five_on, o_deep_sleep_ready, o_force_deep_sleep;
  int err_count = 0, comparisons = 0;
  // ***************************
  // reference model state
  // ***************************
  logic ch = 1, bk1 = 1, bk2 = 1, l1 = 1, l2 = 1, l3 = 1, l4 = 1, l5 = 1, pm = 1;
  logic dsr = 0, fds = 0;
  logic [4:0] msk = 5'h1F, evt = 5'h00;
  always #5 i_clk = ~i_clk;
  assign i_sda = ~(sda_low | o_sda_oe);
  host_model host (.i_clk, .i_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda_low(sda_low));
  pmic_ctrl dut (.i_clk, .i_nrst, .i_ce, .i_scl, .i_sda, .o_sda_o, .o_sda_oe, .o_int_o,
    .o_int_oe, .i_above_undervoltage_lockout, .i_charge_timeout, .i_low_battery, .i_charge_done,
    .i_power_enable_pin, .o_charger_on, .o_buck_one_on, .o_buck_two_on, .o_linreg_one_on,
    .o_linreg_two_on, .o_linreg_three_on, .o_linreg_four_on, .o_linreg_five_on,
    .o_deep_sleep_ready, .o_force_deep_sleep);
  // ***************************
  // shared tasks
  // ***************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic check_rails;
    logic p;
    p = i_power_enable_pin;
    `CHK(o_charger_on, ch, "charger")
    `CHK(o_buck_one_on, bk1, "buck one")
    `CHK(o_buck_two_on, bk2 & (pm | p), "buck two")
    `CHK({o_linreg_one_on, o_linreg_three_on}, {l1, l3}, "linreg one three")
    `CHK({o_linreg_four_on, o_linreg_five_on}, {l4, l5}, "linreg four five")
    `CHK(o_linreg_two_on, l2 & p, "linreg two")
    `CHK(o_deep_sleep_ready, dsr, "sleep ready")
    `CHK(o_force_deep_sleep, fds, "force sleep")
  endtask : check_rails
  task automatic wr(input logic [7:0] b2, input logic [7:0] b3, input bit three);
    logic ok;
    host.write_cmd(b2, b3, three, ok);
    `CHK(ok, 1'b1, "write not acked")
    case (b2[7:5])
      3'h1: {l5, l4, dsr, fds} = b2[4:1];
      3'h2: ch = b2[0];
      3'h0:
        if (three && b2[2:0] == 3'h0 && b3[7:6] == 2'h1) {l3, l2, l1, bk1, bk2, pm} = b3[5:0];
        else if (three && b2[2:0] == 3'h0 && b3[7:6] == 2'h2)
          msk = {b3[5:4], b3[2:0]};
      default: ;
    endcase
    repeat (8) @(posedge i_clk);
  endtask : wr
  task automatic rd(input string m);
    logic [7:0] d;
    logic ok;
    host.read_status(d, ok);
    `CHK(ok, 1'b1, "read address not acked")
    `CHK(d, {evt[4:3], 1'b0, evt[2:0], dsr, fds}, m)
    evt = 5'h00;
    repeat (4) @(posedge i_clk);
    `CHK(o_int_oe, 1'b0, "interrupt held after read")
  endtask : rd
  // ***************************
  // test sequence
  // ***************************
  initial
  begin
    logic [7:0] b2, b3;
    void'($urandom(32'h009E26DF));
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (12) @(posedge i_clk);
    check_rails();
    `CHK(o_int_oe, 1'b0, "interrupt after reset")
    `CHK(o_int_o, 1'b0, "open drain level")
    `CHK(o_sda_o, 1'b0, "open drain data level")
    $display("test reset defaults done");
    for (int n = 0; n < 12; n++)
    begin
      b2 = 8'($urandom);
      b2[7:5] = 3'(n % 4);
      if (n % 4 == 0) b2[2:0] = 3'(n % 8);
      b3 = {2'h1, 6'($urandom)};
      i_power_enable_pin <= 1'($urandom);
      wr(b2, b3, 1);
      check_rails();
    end
    $display("test enable writes done");
    i_ce <= 1'b0;
    i_power_enable_pin <= ~i_power_enable_pin;
    repeat (20) @(posedge i_clk);
    `CHK(o_linreg_two_on, l2 & ~i_power_enable_pin, "state moved while enable low")
    i_ce <= 1'b1;
    repeat (12) @(posedge i_clk);
    check_rails();
    $display("test clock enable done");
    for (int m = 1; m >= 0; m--)
      for (int k = 4; k >= 0; k--)
      begin
        b3 = 8'h1F;
        b3[k] = m[0];
        wr(8'h00, {2'h2, b3[4:3], 1'b0, b3[2:0]}, 1);
        case (k)
          4: i_above_undervoltage_lockout <= 1'b1;
          3: i_above_undervoltage_lockout <= 1'b0;
          2: i_low_battery <= 1'b1;
          1: i_charge_timeout <= 1'b1;
          default: i_charge_done <= 1'b1;
        endcase
        evt[k] = 1'b1;
        for (int w = 0; w < 40 && o_int_oe !== 1'b1; w++) @(posedge i_clk);
        `CHK(o_int_oe, 1'(m == 0), "interrupt level")
        rd("status after event");
        {i_low_battery, i_charge_timeout, i_charge_done} <= 3'h0;
        repeat (10) @(posedge i_clk);
        rd("status after clear");
        $display("test event %0d mask %0d done", k, m);
      end
    print_verdict();
  end
  initial
  begin
    #300_000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_top
